// ---- hw/amp_ctrl_pkg.sv ----
package amp_ctrl_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Gains travel as signed half-decibel counts so that 1.5 dB steps stay exact.
    localparam int GAIN_W = 9;
    localparam int VOL_W = 5;
    localparam int STAGE_W = 2;

    // Register offsets.
    localparam logic [ADDR_W-1:0] SHUTDOWN_CTRL_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] OUTPUT_ONOFF_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] MONO_VOLUME_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] LEFT_VOLUME_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] RIGHT_VOLUME_OFS = 3'h4;
    localparam logic [ADDR_W-1:0] STAGE_GAIN_OFS = 3'h5;
    localparam logic [ADDR_W-1:0] INPUT_MODE_OFS = 3'h6;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h7;

    // Field positions.
    localparam int MASTER_POWER_BIT = 0;
    localparam int SPK_LEFT_EN_BIT = 0;
    localparam int SPK_RIGHT_EN_BIT = 1;
    localparam int HP_LEFT_EN_BIT = 2;
    localparam int HP_RIGHT_EN_BIT = 3;
    localparam int SPK_LEFT_GAIN_LSB = 0;
    localparam int SPK_RIGHT_GAIN_LSB = 2;
    localparam int HP_GAIN_LSB = 4;
    localparam int MODE_SEL_A_BIT = 1;
    localparam int MODE_SEL_B_BIT = 0;
    localparam int STATUS_CONFIG_LSB = 4;
    localparam int STATUS_SINGLE_BIT = 7;

    // Reset values: powered down, outputs off, quietest volume, least stage gain.
    localparam logic POWER_RESET = 1'b0;
    localparam logic [3:0] ONOFF_RESET = 4'h0;
    localparam logic [VOL_W-1:0] VOLUME_RESET = 5'h00;
    localparam logic [STAGE_W-1:0] SPK_STAGE_RESET = 2'h3;
    localparam logic [STAGE_W-1:0] HP_STAGE_RESET = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // Volume: coarse segment for the lowest codes, then a uniform ramp.
    localparam logic [VOL_W-1:0] VOL_FINE_FIRST = 5'h09;
    localparam logic signed [GAIN_W-1:0] VOL_ZERO_CODE = 9'sh013;
    localparam logic signed [GAIN_W-1:0] VOL_STEP_HDB = 9'sh003;
    localparam logic signed [GAIN_W-1:0] VOL_COARSE_HDB [0:8] = '{
        -9'sh072, -9'sh062, -9'sh054, -9'sh045, -9'sh03D,
        -9'sh036, -9'sh030, -9'sh02A, -9'sh024};

    // Output stages.
    localparam logic signed [GAIN_W-1:0] SPK_STEP_HDB = 9'sh004;
    localparam logic signed [GAIN_W-1:0] SPK_SINGLE_BOOST_HDB = 9'sh00C;
    localparam logic signed [GAIN_W-1:0] HP_0DB_HDB = 9'sh000;
    localparam logic signed [GAIN_W-1:0] HP_M6DB_HDB = -9'sh00C;
    localparam logic signed [GAIN_W-1:0] HP_M12DB_HDB = -9'sh018;

    // Input mode pair {select_a, select_b}.
    localparam logic [1:0] MODE_DIFF = 2'h0;
    localparam logic [1:0] MODE_NEG_ONLY = 2'h1;
    localparam logic [1:0] MODE_POS_ONLY = 2'h2;
    localparam logic [1:0] MODE_MIXED = 2'h3;

    // Shutdown configurations.
    localparam logic [2:0] CFG_FULL_SHUTDOWN = 3'h0;
    localparam logic [2:0] CFG_OUTPUTS_OFF = 3'h1;
    localparam logic [2:0] CFG_SPEAKERS_ONLY = 3'h2;
    localparam logic [2:0] CFG_HEADPHONES_ONLY = 3'h3;
    localparam logic [2:0] CFG_ALL_OUTPUTS = 3'h4;

endpackage

// ---- hw/amp_gain_shutdown_ctrl.sv ----
// Operation
// - Master power bit high powers the whole device; low powers it down.
// - Output bits 3..0 enable right headphone, left headphone, right speaker, left speaker.
// - Mono, left and right paths each have a 5-bit, 32-step volume code.
// - Codes 0 to 8 follow a coarse non-uniform table from -57 dB.
// - From code 9 upward each step adds 1.5 dB; code 19 is 0 dB.
// - Path total gain is volume level plus that path's output-stage gain.
// - Speaker stage codes give 6,4,2,0 dB, or 12,10,8,6 dB with one signal.
// - One single-ended signal per channel raises speaker gain by 6 dB.
// - Headphone stage codes 00, 01, 10 give 0, -6, -12 dB.
// - Headphone stage gain ignores the stereo input mode.
// - Both mode select bits clear puts stereo inputs in differential mode.
// - Mono path is always differential and ignores the mode select bits.
// - Five shutdown configurations come from power and channel enable writes.
// - Mode 01 negative inputs, 10 positive inputs, 11 both inputs mixed.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module amp_gain_shutdown_ctrl
    import amp_ctrl_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic CE,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [DATA_W-1:0] REG_RDATA,
    output logic DEVICE_POWERED,
    output logic [3:0] CHANNEL_ACTIVE,
    output logic [2:0] SHUTDOWN_CONFIG,
    output logic [1:0] STEREO_INPUT_MODE,
    output logic MONO_DIFFERENTIAL,
    output logic SPK_SINGLE_SIGNAL,
    output logic signed [GAIN_W-1:0] SPK_LEFT_GAIN,
    output logic signed [GAIN_W-1:0] SPK_RIGHT_GAIN,
    output logic signed [GAIN_W-1:0] HP_LEFT_GAIN,
    output logic signed [GAIN_W-1:0] HP_RIGHT_GAIN,
    output logic signed [GAIN_W-1:0] MONO_SPK_LEFT_GAIN,
    output logic signed [GAIN_W-1:0] MONO_SPK_RIGHT_GAIN,
    output logic signed [GAIN_W-1:0] MONO_HP_GAIN
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers, each used for several paths.
    // Half-decibel units keep every step an integer.

    // Volume code to half-decibel gain.
    // Low codes are irregular and sit in a table;
    // above them a subtract and multiply do the work.
    function automatic logic signed [GAIN_W-1:0] volume_hdb(input logic [VOL_W-1:0] code);
        logic signed [GAIN_W-1:0] fine;

        fine = ($signed({4'h0, code}) - VOL_ZERO_CODE) * VOL_STEP_HDB;
        if (code < VOL_FINE_FIRST) begin
            volume_hdb = VOL_COARSE_HDB[code[3:0]];
        end else begin
            volume_hdb = fine;
        end
    endfunction

    // Speaker stage: two decibels per code step, six more with a lone signal.
    // Higher codes mean less gain, hence the inversion.
    function automatic logic signed [GAIN_W-1:0] speaker_stage_hdb(
        input logic [STAGE_W-1:0] code,
        input logic single
    );
        logic signed [GAIN_W-1:0] base;

        base = $signed({7'h00, ~code}) * SPK_STEP_HDB;
        if (single) begin
            speaker_stage_hdb = base + SPK_SINGLE_BOOST_HDB;
        end else begin
            speaker_stage_hdb = base;
        end
    endfunction

    // Headphone stage; no mode input, so the input mode cannot reach it.
    // Code 11 takes the quietest entry, so a stray write
    // never makes the headphones louder than a legal one.
    function automatic logic signed [GAIN_W-1:0] headphone_stage_hdb(
        input logic [STAGE_W-1:0] code
    );
        case (code)
            2'h0: headphone_stage_hdb = HP_0DB_HDB;
            2'h1: headphone_stage_hdb = HP_M6DB_HDB;
            2'h2: headphone_stage_hdb = HP_M12DB_HDB;
            default: headphone_stage_hdb = HP_M12DB_HDB;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Software-written settings.
    // Settings may be written while powered down, so a
    // host can prepare gains before turning outputs on.

    // Power and channel enables.
    logic power_reg;
    logic [3:0] onoff_reg;

    // Volume codes.
    logic [VOL_W-1:0] mono_volume_reg;
    logic [VOL_W-1:0] left_volume_reg;
    logic [VOL_W-1:0] right_volume_reg;

    // Output-stage codes.
    logic [STAGE_W-1:0] speaker_left_stage_gain;
    logic [STAGE_W-1:0] speaker_right_stage_gain;
    logic [STAGE_W-1:0] headphone_stage_gain;

    // Input mode pair and qualified strobes.
    logic input_mode_select_a;
    logic input_mode_select_b;
    logic wr_en;
    logic rd_en;

    // The bus never waits; a low clock enable simply drops the access.
    // Qualifying here means no register misses the enable.
    assign wr_en = REG_WR && CE;
    assign rd_en = REG_RD && CE;

    // Master power bit.
    // It gates every channel; an enable alone starts nothing.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            power_reg <= POWER_RESET;
        end else if (wr_en && REG_ADDR == SHUTDOWN_CTRL_OFS) begin
            power_reg <= REG_WDATA[MASTER_POWER_BIT];
        end
    end

    // Per-channel output enables.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            onoff_reg <= ONOFF_RESET;
        end else if (wr_en && REG_ADDR == OUTPUT_ONOFF_OFS) begin
            onoff_reg <= REG_WDATA[HP_RIGHT_EN_BIT:SPK_LEFT_EN_BIT];
        end
    end

    // Volume codes for the three input paths.
    // One address per strobe, so one code changes at most.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            mono_volume_reg <= VOLUME_RESET;
            left_volume_reg <= VOLUME_RESET;
            right_volume_reg <= VOLUME_RESET;
        end else if (wr_en) begin
            if (REG_ADDR == MONO_VOLUME_OFS) begin
                mono_volume_reg <= REG_WDATA[VOL_W-1:0];
            end
            if (REG_ADDR == LEFT_VOLUME_OFS) begin
                left_volume_reg <= REG_WDATA[VOL_W-1:0];
            end
            if (REG_ADDR == RIGHT_VOLUME_OFS) begin
                right_volume_reg <= REG_WDATA[VOL_W-1:0];
            end
        end
    end

    // Output-stage gain codes share one register.
    // All three fields load together from one byte.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            speaker_left_stage_gain <= SPK_STAGE_RESET;
            speaker_right_stage_gain <= SPK_STAGE_RESET;
            headphone_stage_gain <= HP_STAGE_RESET;
        end else if (wr_en && REG_ADDR == STAGE_GAIN_OFS) begin
            speaker_left_stage_gain <= REG_WDATA[SPK_LEFT_GAIN_LSB +: STAGE_W];
            speaker_right_stage_gain <= REG_WDATA[SPK_RIGHT_GAIN_LSB +: STAGE_W];
            headphone_stage_gain <= REG_WDATA[HP_GAIN_LSB +: STAGE_W];
        end
    end

    // Stereo input mode pair.
    // Both bits load on one edge; no half mode is decoded.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            input_mode_select_a <= MODE_RESET[MODE_SEL_A_BIT];
            input_mode_select_b <= MODE_RESET[MODE_SEL_B_BIT];
        end else if (wr_en && REG_ADDR == INPUT_MODE_OFS) begin
            input_mode_select_a <= REG_WDATA[MODE_SEL_A_BIT];
            input_mode_select_b <= REG_WDATA[MODE_SEL_B_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational decode of the settings.
    // Nothing here holds state; outputs below register it.

    // Mode and power decode.
    logic [1:0] mode_pair;
    logic single_signal;
    logic [3:0] active_next;
    logic [2:0] config_next;

    // Path levels.
    logic signed [GAIN_W-1:0] vol_mono;
    logic signed [GAIN_W-1:0] vol_left;
    logic signed [GAIN_W-1:0] vol_right;

    // Path stage gains.
    logic signed [GAIN_W-1:0] stage_spk_left;
    logic signed [GAIN_W-1:0] stage_spk_right;
    logic signed [GAIN_W-1:0] stage_mono_spk_left;
    logic signed [GAIN_W-1:0] stage_mono_spk_right;
    logic signed [GAIN_W-1:0] stage_hp;

    assign mode_pair = {input_mode_select_a, input_mode_select_b};

    // Only the one-sided modes leave a lone signal on each stereo channel; the mixed
    // mode applies two signals and so keeps the differential gain column.
    // Mode 00 is plain differential and adds nothing.
    always_comb begin
        case (mode_pair)
            MODE_DIFF: single_signal = 1'b0;
            MODE_NEG_ONLY: single_signal = 1'b1;
            MODE_POS_ONLY: single_signal = 1'b1;
            MODE_MIXED: single_signal = 1'b0;
            default: single_signal = 1'b0;
        endcase
    end

    // A channel runs only when the whole device is powered as well.
    // Power-down keeps the enables for the next power-up.
    assign active_next = power_reg ? onoff_reg : 4'h0;

    // Classify the power and enable combination into one of five configurations.
    // Any enabled channel marks its whole group in use.
    always_comb begin
        config_next = CFG_FULL_SHUTDOWN;
        if (power_reg) begin
            case ({|active_next[HP_RIGHT_EN_BIT:HP_LEFT_EN_BIT],
                   |active_next[SPK_RIGHT_EN_BIT:SPK_LEFT_EN_BIT]})
                2'h0: config_next = CFG_OUTPUTS_OFF;
                2'h1: config_next = CFG_SPEAKERS_ONLY;
                2'h2: config_next = CFG_HEADPHONES_ONLY;
                default: config_next = CFG_ALL_OUTPUTS;
            endcase
        end
    end

    // Per-path level and stage gains.
    // Mono always takes the differential speaker column.
    assign vol_mono = volume_hdb(mono_volume_reg);
    assign vol_left = volume_hdb(left_volume_reg);
    assign vol_right = volume_hdb(right_volume_reg);
    assign stage_spk_left = speaker_stage_hdb(speaker_left_stage_gain, single_signal);
    assign stage_spk_right = speaker_stage_hdb(speaker_right_stage_gain, single_signal);
    assign stage_mono_spk_left = speaker_stage_hdb(speaker_left_stage_gain, 1'b0);
    assign stage_mono_spk_right = speaker_stage_hdb(speaker_right_stage_gain, 1'b0);
    assign stage_hp = headphone_stage_hdb(headphone_stage_gain);

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs: state and path totals.

    // Power and channel state; registering costs one cycle but gives clean levels.
    // All outputs move on one edge; no mixed state shows.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            DEVICE_POWERED <= 1'b0;
            CHANNEL_ACTIVE <= 4'h0;
            SHUTDOWN_CONFIG <= CFG_FULL_SHUTDOWN;
            STEREO_INPUT_MODE <= MODE_DIFF;
            MONO_DIFFERENTIAL <= 1'b1;
            SPK_SINGLE_SIGNAL <= 1'b0;
        end else if (CE) begin
            DEVICE_POWERED <= power_reg;
            CHANNEL_ACTIVE <= active_next;
            SHUTDOWN_CONFIG <= config_next;
            STEREO_INPUT_MODE <= mode_pair;
            MONO_DIFFERENTIAL <= 1'b1;
            SPK_SINGLE_SIGNAL <= single_signal;
        end
    end

    // Totals are level plus stage; ranges stay well inside the signed width.
    // All three headphone totals share one stage code.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            SPK_LEFT_GAIN <= '0;
            SPK_RIGHT_GAIN <= '0;
            HP_LEFT_GAIN <= '0;
            HP_RIGHT_GAIN <= '0;
            MONO_SPK_LEFT_GAIN <= '0;
            MONO_SPK_RIGHT_GAIN <= '0;
            MONO_HP_GAIN <= '0;
        end else if (CE) begin
            SPK_LEFT_GAIN <= vol_left + stage_spk_left;
            SPK_RIGHT_GAIN <= vol_right + stage_spk_right;
            HP_LEFT_GAIN <= vol_left + stage_hp;
            HP_RIGHT_GAIN <= vol_right + stage_hp;
            MONO_SPK_LEFT_GAIN <= vol_mono + stage_mono_spk_left;
            MONO_SPK_RIGHT_GAIN <= vol_mono + stage_mono_spk_right;
            MONO_HP_GAIN <= vol_mono + stage_hp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read-back path.

    logic [DATA_W-1:0] read_mux;

    // Unused bits and unmapped offsets read as zero.
    // Status shows registered outputs, a cycle later.
    always_comb begin
        read_mux = '0;
        case (REG_ADDR)
            SHUTDOWN_CTRL_OFS: read_mux[MASTER_POWER_BIT] = power_reg;
            OUTPUT_ONOFF_OFS: read_mux[HP_RIGHT_EN_BIT:SPK_LEFT_EN_BIT] = onoff_reg;
            MONO_VOLUME_OFS: read_mux[VOL_W-1:0] = mono_volume_reg;
            LEFT_VOLUME_OFS: read_mux[VOL_W-1:0] = left_volume_reg;
            RIGHT_VOLUME_OFS: read_mux[VOL_W-1:0] = right_volume_reg;
            STAGE_GAIN_OFS: begin
                read_mux[SPK_LEFT_GAIN_LSB +: STAGE_W] = speaker_left_stage_gain;
                read_mux[SPK_RIGHT_GAIN_LSB +: STAGE_W] = speaker_right_stage_gain;
                read_mux[HP_GAIN_LSB +: STAGE_W] = headphone_stage_gain;
            end
            INPUT_MODE_OFS: begin
                read_mux[MODE_SEL_A_BIT] = input_mode_select_a;
                read_mux[MODE_SEL_B_BIT] = input_mode_select_b;
            end
            STATUS_OFS: begin
                read_mux[HP_RIGHT_EN_BIT:SPK_LEFT_EN_BIT] = CHANNEL_ACTIVE;
                read_mux[STATUS_CONFIG_LSB +: 3] = SHUTDOWN_CONFIG;
                read_mux[STATUS_SINGLE_BIT] = SPK_SINGLE_SIGNAL;
            end
            default: read_mux = '0;
        endcase
    end

    // Read data stand only in the cycle after the strobe; otherwise zero.
    // Zero between reads keeps stale data off the bus.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            REG_RDATA <= '0;
        end else if (CE) begin
            REG_RDATA <= rd_en ? read_mux : '0;
        end
    end

endmodule

// ---- bench/amp_ctrl_host.sv ----
module amp_ctrl_host
    import amp_ctrl_pkg::*;
(
    input logic clk,
    input logic [DATA_W-1:0] reg_rdata,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    timeunit 1ns;
    timeprecision 100ps;

    // The bus is quiet at time zero.
    initial begin
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One-cycle write; a released bus shows the inverse so stale values cannot pass.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // One-cycle read; the data is taken in the single cycle where it stands.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

// ---- bench/amp_gain_shutdown_ctrl_props.sv ----
module amp_ctrl_props
    import amp_ctrl_pkg::*;
(
    input logic CLK_SYS,
    input logic RESET,
    input logic CE,
    input logic [ADDR_W-1:0] REG_ADDR,
    input logic [DATA_W-1:0] REG_WDATA,
    input logic REG_WR,
    input logic REG_RD,
    input logic [DATA_W-1:0] REG_RDATA,
    input logic DEVICE_POWERED,
    input logic [3:0] CHANNEL_ACTIVE,
    input logic [2:0] SHUTDOWN_CONFIG,
    input logic [1:0] STEREO_INPUT_MODE,
    input logic MONO_DIFFERENTIAL,
    input logic SPK_SINGLE_SIGNAL,
    input logic signed [GAIN_W-1:0] SPK_LEFT_GAIN,
    input logic signed [GAIN_W-1:0] HP_LEFT_GAIN,
    input logic signed [GAIN_W-1:0] HP_RIGHT_GAIN
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    ////////////////////////////////////////////////////////////////////////////////
    // Writes land on the derived outputs one edge after the write is taken, so the second sample sees them.
    a_power_follow: assert property (REG_WR && CE && REG_ADDR == SHUTDOWN_CTRL_OFS
        |-> ##2 DEVICE_POWERED == $past(REG_WDATA[0], 2)) else $error("power bit not followed");
    a_channel_and: assert property (REG_WR && CE
        && REG_ADDR == OUTPUT_ONOFF_OFS
        |-> ##2 CHANNEL_ACTIVE == ($past(REG_WDATA[3:0], 2) & {4{DEVICE_POWERED}}))
        else $error("channel enables wrong");
    a_mode_load: assert property (REG_WR && CE && REG_ADDR == INPUT_MODE_OFS
        |-> ##2 STEREO_INPUT_MODE == $past(REG_WDATA[1:0], 2)) else $error("input mode wrong");
    a_config_class: assert property (SHUTDOWN_CONFIG == (!DEVICE_POWERED ? 3'h0 :
        CHANNEL_ACTIVE == 4'h0 ? 3'h1 : CHANNEL_ACTIVE[3:2] == 2'h0 ? 3'h2 :
        CHANNEL_ACTIVE[1:0] == 2'h0 ? 3'h3 : 3'h4)) else $error("shutdown config wrong");
    a_single_mode: assert property (SPK_SINGLE_SIGNAL == (STEREO_INPUT_MODE == 2'h1 ||
        STEREO_INPUT_MODE == 2'h2)) else $error("single signal flag wrong");
    a_mono_diff: assert property (MONO_DIFFERENTIAL)
        else $error("mono not differential");
    a_status_read: assert property (REG_RD && CE && REG_ADDR == STATUS_OFS
        |=> REG_RDATA ==
        {$past(SPK_SINGLE_SIGNAL), $past(SHUTDOWN_CONFIG), $past(CHANNEL_ACTIVE)})
        else $error("status read wrong");

    // A lone mode change must leave headphones alone; a lone single-signal flip must move the left speaker by exactly 6 dB.
    a_hp_free: assert property ($changed(STEREO_INPUT_MODE) &&
        !$past(REG_WR && CE && REG_ADDR != INPUT_MODE_OFS, 2)
        |-> $stable(HP_LEFT_GAIN) && $stable(HP_RIGHT_GAIN)) else $error("hp gain moved");
    a_spk_boost: assert property ($changed(SPK_SINGLE_SIGNAL) &&
        !$past(REG_WR && CE && REG_ADDR != INPUT_MODE_OFS, 2)
        |-> SPK_LEFT_GAIN == $past(SPK_LEFT_GAIN) + (SPK_SINGLE_SIGNAL ? 12 : -12))
        else $error("speaker boost wrong");
endmodule

bind amp_gain_shutdown_ctrl amp_ctrl_props amp_ctrl_props_inst (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DEVICE_POWERED(DEVICE_POWERED),
    .CHANNEL_ACTIVE(CHANNEL_ACTIVE), .SHUTDOWN_CONFIG(SHUTDOWN_CONFIG),
    .STEREO_INPUT_MODE(STEREO_INPUT_MODE), .MONO_DIFFERENTIAL(MONO_DIFFERENTIAL),
    .SPK_SINGLE_SIGNAL(SPK_SINGLE_SIGNAL), .SPK_LEFT_GAIN(SPK_LEFT_GAIN),
    .HP_LEFT_GAIN(HP_LEFT_GAIN), .HP_RIGHT_GAIN(HP_RIGHT_GAIN));

// ---- bench/testbench.sv ----
module testbench
    import amp_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rd_val;
    logic wr, rd, powered, mono_diff, single;
    logic [3:0] active;
    logic [2:0] cfg;
    logic [1:0] mode;
    logic signed [GAIN_W-1:0] spk_l, spk_r, hp_l, hp_r, m_spk_l, m_spk_r, m_hp;
    logic [DATA_W-1:0] sh [0:6];
    int n_mismatch = 0;
    int checked = 0;
    localparam logic [DATA_W-1:0] MASK [0:6] = '{8'h01, 8'h0F, 8'h1F, 8'h1F, 8'h1F, 8'h3F, 8'h03};
    localparam logic [DATA_W-1:0] RST_VAL [0:6] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h2F, 8'h00};

    amp_gain_shutdown_ctrl amp_gain_shutdown_ctrl_inst (
        .CLK_SYS(clk), .RESET(rst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .DEVICE_POWERED(powered), .CHANNEL_ACTIVE(active),
        .SHUTDOWN_CONFIG(cfg), .STEREO_INPUT_MODE(mode), .MONO_DIFFERENTIAL(mono_diff),
        .SPK_SINGLE_SIGNAL(single), .SPK_LEFT_GAIN(spk_l), .SPK_RIGHT_GAIN(spk_r),
        .HP_LEFT_GAIN(hp_l), .HP_RIGHT_GAIN(hp_r), .MONO_SPK_LEFT_GAIN(m_spk_l),
        .MONO_SPK_RIGHT_GAIN(m_spk_r), .MONO_HP_GAIN(m_hp));
    amp_ctrl_host amp_ctrl_host_inst (.clk(clk), .reg_rdata(rdata), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd));

    ////////////////////////////////////////////////////////////////////////////////
    // Expected gains in half decibels, worked out independently of the design.
    function automatic int vol_hdb(input logic [4:0] c);
        int coarse [0:8] = '{-114, -98, -84, -69, -61, -54, -48, -42, -36};
        return (c < 9) ? coarse[c] : (int'(c) - 19) * 3;
    endfunction
    function automatic int spk_hdb(input logic [1:0] c, input logic s);
        return (3 - int'(c)) * 4 + (s ? 12 : 0);
    endfunction
    function automatic int hp_hdb(input logic [1:0] c);
        return (c == 2'h0) ? 0 : (c == 2'h1) ? -12 : -24;
    endfunction

    // Compare tasks count every check and report each mismatch at once.
    task automatic cmp_val(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_gain(input string name, input int exp, input logic signed [8:0] got);
        checked++;
        if (got !== 9'(exp)) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d of %0d checks", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // The shadow drops unused bits and ignores the read-only status offset.
    task automatic wrs(input logic [2:0] a, input logic [7:0] d);
        amp_ctrl_host_inst.wr(a, d);
        if (a < 7) sh[a] = d & MASK[a];
    endtask
    task automatic read_all();
        for (int a = 0; a < 7; a++) begin
            amp_ctrl_host_inst.rd(3'(a), rd_val);
            cmp_val("readback", sh[a], rd_val);
        end
    endtask

    // Outputs settle one edge after the write edge, so wait one edge first.
    task automatic check_all();
        logic s;
        logic [3:0] act;
        logic [2:0] c;
        s = sh[6][1:0] == 2'h1 || sh[6][1:0] == 2'h2;
        act = sh[1][3:0] & {4{sh[0][0]}};
        c = !sh[0][0] ? 3'h0 : act == 0 ? 3'h1 : act[3:2] == 0 ? 3'h2 :
            act[1:0] == 0 ? 3'h3 : 3'h4;
        @(posedge clk);
        #1;
        cmp_val("powered", {7'h0, sh[0][0]}, {7'h0, powered});
        cmp_val("active", {4'h0, act}, {4'h0, active});
        cmp_val("config", {5'h0, c}, {5'h0, cfg});
        cmp_val("mode", sh[6], {6'h0, mode});
        cmp_val("flags", {6'h0, s, 1'b1}, {6'h0, single, mono_diff});
        cmp_gain("spk_l", vol_hdb(sh[3][4:0]) + spk_hdb(sh[5][1:0], s), spk_l);
        cmp_gain("spk_r", vol_hdb(sh[4][4:0]) + spk_hdb(sh[5][3:2], s), spk_r);
        cmp_gain("hp_l", vol_hdb(sh[3][4:0]) + hp_hdb(sh[5][5:4]), hp_l);
        cmp_gain("hp_r", vol_hdb(sh[4][4:0]) + hp_hdb(sh[5][5:4]), hp_r);
        cmp_gain("m_spk_l", vol_hdb(sh[2][4:0]) + spk_hdb(sh[5][1:0], 1'b0), m_spk_l);
        cmp_gain("m_spk_r", vol_hdb(sh[2][4:0]) + spk_hdb(sh[5][3:2], 1'b0), m_spk_r);
        cmp_gain("m_hp", vol_hdb(sh[2][4:0]) + hp_hdb(sh[5][5:4]), m_hp);
        amp_ctrl_host_inst.rd(STATUS_OFS, rd_val);
        cmp_val("status", {s, c, act}, rd_val);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end

    // The whole run needs about 900 cycles; this leaves wide margin.
    initial begin
        #50000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        void'($urandom(26370));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        sh = RST_VAL;
        check_all();
        read_all();
        // Every volume code on both stereo paths, all headphone stage codes, all input modes.
        for (int c = 0; c < 32; c++) begin
            wrs(LEFT_VOLUME_OFS, {3'($urandom), 5'(c)});
            wrs(RIGHT_VOLUME_OFS, 8'(31 - c));
            wrs(MONO_VOLUME_OFS, 8'($urandom));
            wrs(STAGE_GAIN_OFS, {2'($urandom), 2'(c), 4'($urandom)});
            wrs(INPUT_MODE_OFS, 8'(c));
            check_all();
        end
        // All enable patterns with power off and on give the five configurations.
        for (int k = 0; k < 32; k++) begin
            wrs(OUTPUT_ONOFF_OFS, {4'($urandom), 4'(k)});
            wrs(SHUTDOWN_CTRL_OFS, {7'($urandom), 1'(k >> 4)});
            check_all();
        end
        // Random writes, the read-only status offset among them.
        repeat (40) begin
            wrs(3'($urandom), 8'($urandom));
            check_all();
        end
        read_all();
        // A write while the clock enable is low must be ignored.
        @(posedge clk);
        ce <= 1'b0;
        amp_ctrl_host_inst.wr(SHUTDOWN_CTRL_OFS, ~sh[0]);
        @(posedge clk);
        ce <= 1'b1;
        check_all();
        // A second reset in mid-run brings back the reset values.
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        sh = RST_VAL;
        check_all();
        read_all();
        give_verdict();
    end
endmodule
